// ### shared/ibr_pkg.sv
// Package for the instrument bus remote-control block.
// Assumes an APB master on pclk and decoded interface messages as inputs.
package ibr_pkg;
  // ****************************************************
  // Register map (byte addresses)
  // ****************************************************
  localparam logic [7:0] IBR_CTRL_OFS = 8'h00;
  localparam logic [7:0] IBR_STAT_OFS = 8'h04;
  localparam logic [7:0] IBR_SRE_OFS = 8'h08;
  localparam logic [7:0] IBR_ARM_OFS = 8'h0c;
  localparam logic [7:0] IBR_PRM_OFS = 8'h10;
  localparam logic [7:0] IBR_RES_OFS = 8'h14;
  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int IBR_CTRL_BUSTRIG = 0;
  localparam int IBR_CTRL_ADDR_LO = 1;
  localparam int IBR_ST_REMOTE = 0;
  localparam int IBR_ST_LLO = 1;
  localparam int IBR_ST_TALK = 2;
  localparam int IBR_ST_LISTEN = 3;
  localparam int IBR_ST_SRQ = 4;
  localparam int IBR_RES_VALID = 8;
  localparam int IBR_RES_KIND = 9;
  // ****************************************************
  // Reset values and limits (arm timer in milliseconds)
  // ****************************************************
  localparam logic [4:0] IBR_ADDR_RST = 5'h0e;
  localparam logic [7:0] IBR_SRE_RST = 8'h00;
  localparam logic [31:0] IBR_ARM_DEF = 32'h0000_0064;
  localparam logic [31:0] IBR_ARM_MIN = 32'h0000_0001;
  localparam logic [31:0] IBR_ARM_MAX = 32'h3b9a_c9ff;
  localparam int IBR_IFC_MIN_US = 100;
  localparam int IBR_CLK_MHZ = 25;
  localparam int IBR_IFC_CYC = IBR_IFC_MIN_US * IBR_CLK_MHZ;
  // ****************************************************
  // Parser characters
  // ****************************************************
  localparam logic [7:0] IBR_CH_SP = 8'h20;
  localparam logic [7:0] IBR_CH_HASH = 8'h23;
  localparam logic [7:0] IBR_CH_LF = 8'h0a;
  localparam logic [7:0] IBR_CH_0 = 8'h30;
  localparam logic [7:0] IBR_CH_A = 8'h41;
  localparam logic [7:0] IBR_CASE = 8'hdf;
  // Parameter kinds reported in the result register
  typedef enum logic [2:0] {
    IBR_K_NONE, IBR_K_BOOL, IBR_K_NDN, IBR_K_DEF, IBR_K_MIN, IBR_K_MAX,
    IBR_K_ERR
  } ibr_kind_t;
  typedef enum {
    IBR_P_WORD, IBR_P_GAP, IBR_P_RADIX, IBR_P_DIGITS, IBR_P_NAME
  } ibr_pstate_t;
endpackage

// ### hw/ibr_remote.sv
// Remote-control state, bus messages and parameter parser of an instrument.
// Assumes interface messages arrive decoded as one-cycle pulses on pclk;
// front-panel keys and the parser byte stream come from pclk logic too.
`timescale 1ns/1ps
module ibr_remote
  import ibr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ren_pin,
  input wire logic ifc_pin,
  input wire logic msg_llo,
  input wire logic msg_gtl,
  input wire logic msg_dcl,
  input wire logic msg_sdc,
  input wire logic msg_get,
  input wire logic msg_spe,
  input wire logic msg_spd,
  input wire logic msg_unt,
  input wire logic msg_unl,
  input wire logic msg_mla_any,
  input wire logic [4:0] msg_mla_addr,
  input wire logic msg_mta_any,
  input wire logic [4:0] msg_mta_addr,
  input wire logic poll_byte_read,
  input wire logic [7:0] status_cond,
  input wire logic key_local,
  input wire logic key_other,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic remote_state_indicator,
  output logic talk_indicator,
  output logic listener_active_indicator,
  output logic srq_indicator,
  output logic srq_out,
  output logic poll_active,
  output logic [7:0] poll_byte,
  output logic lockout,
  output logic key_accept,
  output logic configure_pulse,
  output logic display_restore,
  output logic device_clear,
  output logic trigger_event
);
  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic ren_s1_reg, ren_reg, ifc_s1_reg, ifc_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ren_s1_reg <= 1'b0;
      ren_reg <= 1'b0;
      ifc_s1_reg <= 1'b0;
      ifc_reg <= 1'b0;
    end else begin
      ren_s1_reg <= ren_pin;
      ren_reg <= ren_s1_reg;
      ifc_s1_reg <= ifc_pin;
      ifc_reg <= ifc_s1_reg;
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  logic [31:0] ctrl_reg, arm_reg;
  logic [7:0] sre_reg;
  logic [31:0] prm_reg;
  logic [2:0] kind_reg;
  logic res_valid_reg;
  logic [4:0] my_addr;
  logic bus_trig_sel;
  assign my_addr = ctrl_reg[IBR_CTRL_ADDR_LO +: 5];
  assign bus_trig_sel = ctrl_reg[IBR_CTRL_BUSTRIG];

  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  logic addr_ok;
  always_comb begin
    unique case (paddr)
      IBR_CTRL_OFS, IBR_STAT_OFS, IBR_SRE_OFS, IBR_ARM_OFS,
      IBR_PRM_OFS, IBR_RES_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  logic listen_reg, talk_reg, remote_reg, llo_reg, srq_reg;
  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[IBR_ST_REMOTE] = remote_reg;
    stat_word[IBR_ST_LLO] = llo_reg;
    stat_word[IBR_ST_TALK] = talk_reg;
    stat_word[IBR_ST_LISTEN] = listen_reg;
    stat_word[IBR_ST_SRQ] = srq_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        IBR_CTRL_OFS: prdata <= ctrl_reg;
        IBR_STAT_OFS: prdata <= stat_word;
        IBR_SRE_OFS: prdata <= {24'h00_0000, sre_reg};
        IBR_ARM_OFS: prdata <= arm_reg;
        IBR_PRM_OFS: prdata <= prm_reg;
        IBR_RES_OFS: prdata <= {20'h0_0000, kind_reg, res_valid_reg,
                                8'h00};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Settings live here: no bus message touches them (device clear, IFC)
  logic nd_done, name_done;
  logic [2:0] name_kind;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= {26'h000_0000, IBR_ADDR_RST, 1'b0};
    end else if (wr_en && paddr == IBR_CTRL_OFS) begin
      ctrl_reg <= pwdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sre_reg <= IBR_SRE_RST;
    end else if (wr_en && paddr == IBR_SRE_OFS) begin
      sre_reg <= pwdata[7:0];
    end else if (nd_done) begin
      sre_reg <= prm_reg[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_reg <= IBR_ARM_DEF;
    end else if (wr_en && paddr == IBR_ARM_OFS) begin
      if (pwdata < IBR_ARM_MIN) arm_reg <= IBR_ARM_MIN;
      else if (pwdata > IBR_ARM_MAX) arm_reg <= IBR_ARM_MAX;
      else arm_reg <= pwdata;
    end else if (name_done) begin
      unique case (name_kind)
        IBR_K_DEF: arm_reg <= IBR_ARM_DEF;
        IBR_K_MIN: arm_reg <= IBR_ARM_MIN;
        IBR_K_MAX: arm_reg <= IBR_ARM_MAX;
        default: arm_reg <= arm_reg;
      endcase
    end
  end

  // ****************************************************
  // Interface state machine
  // ****************************************************
  logic own_mla, own_mta;
  assign own_mla = msg_mla_any && msg_mla_addr == my_addr;
  assign own_mta = msg_mta_any && msg_mta_addr == my_addr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      listen_reg <= 1'b0;
    end else if (ifc_reg || msg_unl || own_mta) begin
      listen_reg <= 1'b0;
    end else if (own_mla) begin
      listen_reg <= 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      talk_reg <= 1'b0;
    end else if (ifc_reg || msg_unt || own_mla) begin
      talk_reg <= 1'b0;
    end else if (own_mta) begin
      talk_reg <= 1'b1;
    end
  end
  logic local_ok;
  assign local_ok = key_local && remote_reg && !llo_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_reg <= 1'b0;
    end else if (ifc_reg || !ren_reg || msg_gtl || local_ok) begin
      remote_reg <= 1'b0;
    end else if (own_mla) begin
      remote_reg <= 1'b1;
    end
  end
  // Lockout is released only by go-to-local or REN falling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      llo_reg <= 1'b0;
    end else if (msg_gtl || !ren_reg) begin
      llo_reg <= 1'b0;
    end else if (msg_llo) begin
      llo_reg <= 1'b1;
    end
  end

  // ****************************************************
  // Clear, trigger, poll, service request
  // ****************************************************
  logic poll_reg;
  logic [7:0] stb;
  logic srq_cause;
  assign srq_cause = |(status_cond & sre_reg);
  always_comb begin
    stb = status_cond;
    stb[6] = srq_reg;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srq_reg <= 1'b0;
    end else if (!srq_cause) begin
      srq_reg <= 1'b0;
    end else if (!srq_reg) begin
      srq_reg <= 1'b1;
    end else if (poll_byte_read) begin
      srq_reg <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_reg <= 1'b0;
      poll_byte <= 8'h00;
    end else begin
      if (msg_spe) poll_reg <= 1'b1;
      else if (msg_spd || ifc_reg) poll_reg <= 1'b0;
      if (msg_spe) poll_byte <= stb;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_clear <= 1'b0;
      trigger_event <= 1'b0;
      configure_pulse <= 1'b0;
      display_restore <= 1'b0;
    end else begin
      device_clear <= msg_dcl || (msg_sdc && listen_reg);
      trigger_event <= msg_get && bus_trig_sel;
      configure_pulse <= key_local && !remote_reg && !llo_reg;
      display_restore <= local_ok;
    end
  end
  assign remote_state_indicator = remote_reg;
  assign talk_indicator = talk_reg;
  assign listener_active_indicator = listen_reg;
  assign srq_indicator = srq_reg;
  assign srq_out = srq_reg;
  assign poll_active = poll_reg;
  assign lockout = llo_reg;
  assign key_accept = key_other && !remote_reg && !llo_reg;

  // ****************************************************
  // Parameter parser
  // ****************************************************
  // Word bytes are skipped, so optional words never change meaning
  ibr_pstate_t pst_reg;
  logic [1:0] radix_reg; // 0 bin, 1 hex, 2 oct
  logic [7:0] up, nm0_reg, nm1_reg;
  logic [3:0] dig;
  logic dig_ok;
  assign up = rx_byte & IBR_CASE;
  always_comb begin
    dig = 4'h0;
    dig_ok = 1'b0;
    if (rx_byte >= IBR_CH_0 && rx_byte < IBR_CH_0 + 8'h0a) begin
      dig = 4'(rx_byte - IBR_CH_0);
      dig_ok = (radix_reg == 2'd1) || (radix_reg == 2'd2 && dig < 4'h8)
               || dig < 4'h2;
    end else if (radix_reg == 2'd1 && up >= IBR_CH_A && up < IBR_CH_A + 8'h06)
    begin
      dig = 4'(up - IBR_CH_A + 8'h0a);
      dig_ok = 1'b1;
    end
  end
  logic eom;
  assign eom = rx_valid && (rx_byte == IBR_CH_LF);
  assign nd_done = eom && pst_reg == IBR_P_DIGITS;
  assign name_done = eom && pst_reg == IBR_P_NAME;
  always_comb begin
    name_kind = IBR_K_ERR;
    if (nm0_reg == "D" && nm1_reg == "E") name_kind = IBR_K_DEF;
    else if (nm0_reg == "M" && nm1_reg == "I") name_kind = IBR_K_MIN;
    else if (nm0_reg == "M" && nm1_reg == "A") name_kind = IBR_K_MAX;
    else if (nm0_reg == "O" && nm1_reg == "N") name_kind = IBR_K_BOOL;
    else if (nm0_reg == "O" && nm1_reg == "F") name_kind = IBR_K_BOOL;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pst_reg <= IBR_P_WORD;
      radix_reg <= 2'd0;
      nm0_reg <= 8'h00;
      nm1_reg <= 8'h00;
      prm_reg <= 32'h0000_0000;
      kind_reg <= IBR_K_NONE;
      res_valid_reg <= 1'b0;
    end else if (device_clear) begin
      // Synchronous flush: an async-style clear here would glitch
      pst_reg <= IBR_P_WORD;
      radix_reg <= 2'd0;
      nm0_reg <= 8'h00;
      nm1_reg <= 8'h00;
      prm_reg <= 32'h0000_0000;
      kind_reg <= IBR_K_NONE;
      res_valid_reg <= 1'b0;
    end else if (rx_valid) begin
      unique case (pst_reg)
        IBR_P_WORD: if (rx_byte == IBR_CH_SP) pst_reg <= IBR_P_GAP;
        IBR_P_GAP: begin
          nm0_reg <= up;
          nm1_reg <= 8'h00;
          prm_reg <= 32'h0000_0000;
          if (rx_byte == IBR_CH_HASH) pst_reg <= IBR_P_RADIX;
          else if (rx_byte == "0" || rx_byte == "1") begin
            prm_reg <= {31'h0, rx_byte[0]};
            kind_reg <= IBR_K_BOOL;
            res_valid_reg <= 1'b1;
            pst_reg <= IBR_P_WORD;
          end else if (rx_byte != IBR_CH_SP) pst_reg <= IBR_P_NAME;
        end
        IBR_P_RADIX: begin
          pst_reg <= IBR_P_DIGITS;
          if (up == "B") radix_reg <= 2'd0;
          else if (up == "H") radix_reg <= 2'd1;
          else if (up == "Q") radix_reg <= 2'd2;
          else pst_reg <= IBR_P_WORD;
        end
        IBR_P_DIGITS: begin
          if (eom) begin
            kind_reg <= IBR_K_NDN;
            res_valid_reg <= 1'b1;
            pst_reg <= IBR_P_WORD;
          end else if (dig_ok) begin
            unique case (radix_reg)
              2'd0: prm_reg <= {prm_reg[30:0], dig[0]};
              2'd1: prm_reg <= {prm_reg[27:0], dig};
              default: prm_reg <= {prm_reg[28:0], dig[2:0]};
            endcase
          end
        end
        IBR_P_NAME: begin
          if (eom) begin
            kind_reg <= name_kind;
            prm_reg <= {31'h0, nm0_reg == "O" && nm1_reg == "N"};
            res_valid_reg <= 1'b1;
            pst_reg <= IBR_P_WORD;
          end else if (nm1_reg == 8'h00) nm1_reg <= up;
        end
      endcase
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  remote_needs_mla_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(remote_reg) |-> $past(own_mla) && $past(ren_reg))
    else $error("remote entered without own listen address");
  talk_any_state_a: assert property (@(posedge pclk) disable iff (!presetn)
    own_mta && !ifc_reg && !msg_unt && !own_mla |=> talk_reg)
    else $error("talker not activated");
  key_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    remote_reg |-> !key_accept)
    else $error("key accepted in remote");
  ifc_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    ifc_reg |=> !talk_reg && !listen_reg && !remote_reg)
    else $error("interface clear not obeyed");
  lockout_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    llo_reg && remote_reg && key_local && ren_reg && !msg_gtl && !ifc_reg
    |=> remote_reg)
    else $error("local key worked under lockout");
  gtl_local_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_gtl |=> !remote_reg && !llo_reg)
    else $error("go to local ignored");
  dcl_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_dcl |=> device_clear ##1 pst_reg == IBR_P_WORD)
    else $error("device clear missed");
  sdc_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_sdc && !msg_dcl && !listen_reg |=> !device_clear)
    else $error("selective clear while unaddressed");
  get_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_event |-> $past(msg_get) && $past(bus_trig_sel))
    else $error("trigger without bus source");
  poll_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_spe |=> poll_active && poll_byte == $past(stb))
    else $error("poll byte not loaded");
  srq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    srq_reg && srq_cause && !poll_byte_read |=> srq_reg)
    else $error("service request dropped early");
  listen_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_unl || own_mta |=> !listen_reg)
    else $error("listener not idled");
  arm_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    arm_reg >= IBR_ARM_MIN && arm_reg <= IBR_ARM_MAX)
    else $error("arm timer out of range");
  remote_cov_c: cover property (@(posedge pclk) $rose(remote_reg));
  poll_cov_c: cover property (@(posedge pclk) msg_spe ##[1:20] msg_spd);
  ndn_cov_c: cover property (@(posedge pclk) nd_done);
  name_cov_c: cover property (@(posedge pclk) name_done);
endmodule

// ### dv/ibr_ctrl_model.sv
// Bus controller model: decoded bus messages, bus lines and command bytes.
// Assumes the device samples all of them on the rising edge of pclk.
`timescale 1ns/1ps
module ibr_ctrl_model
  import ibr_pkg::*;
(
  input wire logic pclk,
  output logic ren_pin,
  output logic ifc_pin,
  output logic [11:0] msg,
  output logic [4:0] addr,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  initial begin
    ren_pin = 1'b0;
    ifc_pin = 1'b0;
    msg = 12'h000;
    addr = IBR_ADDR_RST;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end
  // One-cycle message pulse
  task automatic send(input int i);
    @(posedge pclk);
    msg[i] <= 1'b1;
    @(posedge pclk);
    msg[i] <= 1'b0;
  endtask
  // Bus line level and the address carried by talk/listen messages
  task automatic set_ren(input logic v);
    @(posedge pclk);
    ren_pin <= v;
  endtask
  task automatic set_addr(input logic [4:0] a);
    @(posedge pclk);
    addr <= a;
  endtask
  // Clear line held for its full minimum width
  task automatic clear_if();
    @(posedge pclk);
    ifc_pin <= 1'b1;
    repeat (IBR_IFC_CYC) @(posedge pclk);
    ifc_pin <= 1'b0;
  endtask
  // Space before the parameter, bracket characters never sent
  task automatic line(input string s);
    for (int k = 0; k < s.len(); k++) begin
      @(posedge pclk);
      rx_byte <= s[k];
      rx_valid <= 1'b1;
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    // Released data line must not keep showing the last byte
    rx_byte <= ~rx_byte;
  endtask
endmodule

// ### dv/tb_ibr_remote.sv
// Testbench for the remote-control block: APB tasks and message sequences.
// Assumes a zero-wait APB slave and message pulses taken on pclk edges.
`timescale 1ns/1ps
module tb_ibr_remote
  import ibr_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic pready, pslverr, err, ka;
  logic key_local = 1'b0;
  logic key_other = 1'b0;
  logic [7:0] status_cond = 8'h00;
  logic [11:0] m;
  logic [4:0] adr;
  logic [7:0] rxb, poll_byte;
  logic rxv, ren, ifc, remote_ind, talk, listen, srq_ind, srq_out, poll_act;
  logic lockout;
  logic key_accept, cfg, disp, dclr, trig;
  int mismatches = 0;
  int comparisons = 0;
  int n_dc = 0, n_trig = 0, n_cfg = 0, n_disp = 0;
  string ln[7] = '{"DISP:ENAB 1\n", "DISP:ENAB OFF\n", "INIT:IMM ON\n",
    "*SRE #B10001\n", "*SRE #H1F\n", "*SRE #Q17\n", "ARM:TIM MIN\n"};
  logic [2:0] kd[7] = '{IBR_K_BOOL, IBR_K_BOOL, IBR_K_BOOL, IBR_K_NDN,
    IBR_K_NDN, IBR_K_NDN, IBR_K_MIN};
  logic [7:0] ofs[7] = '{IBR_PRM_OFS, IBR_PRM_OFS, IBR_PRM_OFS, IBR_SRE_OFS,
    IBR_SRE_OFS, IBR_SRE_OFS, IBR_ARM_OFS};
  logic [31:0] vl[7] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0001,
    32'h0000_0011, 32'h0000_001f, 32'h0000_000f, IBR_ARM_MIN};

  always #20 pclk = ~pclk;

  ibr_ctrl_model i_ibr_ctrl_model (.pclk(pclk), .ren_pin(ren),
    .ifc_pin(ifc), .msg(m), .addr(adr), .rx_byte(rxb), .rx_valid(rxv));

  ibr_remote i_ibr_remote (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ren_pin(ren),
    .ifc_pin(ifc), .msg_llo(m[0]), .msg_gtl(m[1]), .msg_dcl(m[2]),
    .msg_sdc(m[3]), .msg_get(m[4]), .msg_spe(m[5]), .msg_spd(m[6]),
    .msg_unt(m[7]), .msg_unl(m[8]), .msg_mla_any(m[9]), .msg_mla_addr(adr),
    .msg_mta_any(m[10]), .msg_mta_addr(adr), .poll_byte_read(m[11]),
    .status_cond(status_cond), .key_local(key_local),
    .key_other(key_other), .rx_byte(rxb), .rx_valid(rxv),
    .remote_state_indicator(remote_ind), .talk_indicator(talk),
    .listener_active_indicator(listen), .srq_indicator(srq_ind),
    .srq_out(srq_out), .poll_active(poll_act), .poll_byte(poll_byte),
    .lockout(lockout), .key_accept(key_accept), .configure_pulse(cfg),
    .display_restore(disp), .device_clear(dclr), .trigger_event(trig));

  // Pulse outputs are counted, so a missed or doubled pulse shows up
  always @(posedge pclk) begin
    n_dc += (dclr === 1'b1);
    n_trig += (trig === 1'b1);
    n_cfg += (cfg === 1'b1);
    n_disp += (disp === 1'b1);
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      test_done();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic st(input logic [4:0] e);
    apb(1'b0, IBR_STAT_OFS, 32'h0000_0000);
    chk(r[4:0], e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Key pulse; the combinational accept is sampled mid-cycle
  task automatic key(input logic loc);
    @(posedge pclk);
    key_local <= loc;
    key_other <= ~loc;
    @(negedge pclk);
    ka = key_accept;
    @(posedge pclk);
    key_local <= 1'b0;
    key_other <= 1'b0;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #800000;
    mismatches++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    st(5'h00);
    chk(r[31:5], 0);
    apb(1'b0, IBR_ARM_OFS, 0);
    chk(r, IBR_ARM_DEF);
    apb(1'b0, 8'h40, 0);
    chk({r, err}, 1);
    i_ibr_ctrl_model.set_ren(1'b1);
    cyc(5);
    st(5'h00);
    i_ibr_ctrl_model.set_addr(5'h03);
    i_ibr_ctrl_model.send(9);
    cyc(3);
    st(5'h00);
    i_ibr_ctrl_model.set_addr(IBR_ADDR_RST);
    i_ibr_ctrl_model.send(10);
    cyc(3);
    st(5'h04);
    i_ibr_ctrl_model.send(9);
    cyc(3);
    st(5'h09);
    key(1'b0);
    chk(ka, 0);
    i_ibr_ctrl_model.send(3);
    cyc(3);
    chk(n_dc, 1);
    i_ibr_ctrl_model.send(8);
    cyc(3);
    st(5'h01);
    i_ibr_ctrl_model.send(3);
    cyc(3);
    chk(n_dc, 1);
    i_ibr_ctrl_model.send(2);
    cyc(3);
    chk(n_dc, 2);
    i_ibr_ctrl_model.send(0);
    cyc(3);
    key(1'b1);
    cyc(3);
    st(5'h03);
    chk({remote_ind, lockout, talk, listen}, 4'b1100);
    i_ibr_ctrl_model.send(1);
    cyc(3);
    chk(remote_ind, 0);
    key(1'b0);
    chk(ka, 1);
    i_ibr_ctrl_model.set_ren(1'b0);
    cyc(5);
    i_ibr_ctrl_model.set_ren(1'b1);
    cyc(3);
    i_ibr_ctrl_model.send(9);
    cyc(5);
    key(1'b1);
    cyc(3);
    st(5'h08);
    chk(n_disp, 1);
    chk(n_cfg, 0);
    key(1'b1);
    cyc(3);
    chk(n_cfg, 1);
    i_ibr_ctrl_model.send(4);
    cyc(3);
    chk(n_trig, 0);
    apb(1'b1, IBR_CTRL_OFS, 32'h0000_001d);
    i_ibr_ctrl_model.send(4);
    cyc(3);
    chk(n_trig, 1);
    i_ibr_ctrl_model.send(9);
    i_ibr_ctrl_model.send(10);
    cyc(3);
    st(5'h05);
    chk({talk, listen}, 2'b10);
    i_ibr_ctrl_model.clear_if();
    cyc(4);
    st(5'h00);
    apb(1'b0, IBR_CTRL_OFS, 0);
    chk(r, 32'h0000_001d);
    i_ibr_ctrl_model.send(10);
    i_ibr_ctrl_model.send(7);
    cyc(3);
    st(5'h00);
    i_ibr_ctrl_model.send(5);
    cyc(3);
    chk({poll_act, poll_byte}, 9'h100);
    i_ibr_ctrl_model.send(6);
    apb(1'b1, IBR_SRE_OFS, 32'h0000_0001);
    status_cond <= 8'h01;
    cyc(4);
    chk({srq_out, srq_ind}, 2'b11);
    i_ibr_ctrl_model.send(5);
    cyc(3);
    chk(poll_byte, 8'h41);
    i_ibr_ctrl_model.send(6);
    status_cond <= 8'h00;
    cyc(4);
    chk({srq_out, srq_ind}, 2'b00);
    for (int k = 0; k < 7; k++) begin
      i_ibr_ctrl_model.line(ln[k]);
      cyc(3);
      apb(1'b0, IBR_RES_OFS, 0);
      chk(r[11:8], {kd[k], 1'b1});
      apb(1'b0, ofs[k], 0);
      chk(r, vl[k]);
    end
    i_ibr_ctrl_model.line("ARM:TIM MAX\n");
    cyc(3);
    apb(1'b0, IBR_ARM_OFS, 0);
    chk(r, IBR_ARM_MAX);
    i_ibr_ctrl_model.line("ARM:TIM DEF\n");
    cyc(3);
    apb(1'b0, IBR_ARM_OFS, 0);
    chk(r, IBR_ARM_DEF);
    test_done();
  end
endmodule
